//--- rtl/boost_tracking_control.sv
// boost supply tracking controller: registers, class-H tracking, class-G stepping
// assumes a register write/read strobe port from the serial control front end,
// audio samples and battery level from logic on the same clock
`timescale 1ns/1ps
module boost_tracking_control #(
  parameter int SAMPLE_W = 24,
  parameter logic [15:0] FULL_SCALE_LSB = 16'hC350,
  parameter int HOLD_US = boost_pkg::HOLD_BASE_US
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  input wire logic SAMPLE_VALID,
  input wire logic [SAMPLE_W-1:0] SAMPLE_DATA,
  input wire boost_pkg::volt_t VBAT_LEVEL,
  output logic BOOST_ENABLE,
  output logic BOOST_BYPASS,
  output boost_pkg::volt_t BOOST_TARGET,
  output logic [2:0] BOOST_LEVEL
);
  import boost_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic class_h;
    logic [1:0] tot;
    logic [1:0] slew;
    boost_mode_t mode;
    logic [4:1][CFG_W-1:0] cfg;
    logic [15:0] rdata;
    volt_t target;
    volt_t last_need;
    logic en;
    logic bypass;
    logic [2:0] level;
    logic [2:0] req;
    logic [TICK_W-1:0] tick_cnt;
    logic [HOLD_W-1:0] hold_cnt;
  } ctrl_state_t;

  ctrl_state_t s;
  ctrl_state_t next_s;
  level_if lvl ();

  // ----------------------------------------------------------------
  // code decoding
  // ----------------------------------------------------------------
  // target code to voltage
  function automatic volt_t tgt_volt(input logic [5:0] code);
    tgt_volt = 16'(TARGET_BASE_LSB + 16'(code) * STEP_LSB); // R19
  endfunction : tgt_volt

  // threshold code to voltage
  function automatic volt_t thr_volt(input logic [5:0] code);
    thr_volt = 16'(THRESH_BASE_LSB + 16'(code) * STEP_LSB); // R20
  endfunction : thr_volt

  // target code usable: nonzero and not reserved
  function automatic logic tgt_ok(input logic [5:0] code);
    tgt_ok = (code != 6'h00) && (code <= TGT_CODE_MAX); // R19
  endfunction : tgt_ok

  // a level pair is usable when both its codes are valid
  function automatic logic pair_ok(input logic [CFG_W-1:0] cfg, input logic [5:0] thr_max);
    pair_ok = tgt_ok(cfg[TGT_LSB +: CODE_W]) && (cfg[THR_LSB +: CODE_W] != 6'h00) &&
              (cfg[THR_LSB +: CODE_W] <= thr_max); // R20
  endfunction : pair_ok

  // ----------------------------------------------------------------
  // estimator
  // ----------------------------------------------------------------
  level_estimator #(
    .SAMPLE_W(SAMPLE_W),
    .FULL_SCALE_LSB(FULL_SCALE_LSB)
  ) u_est (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .sample_valid(SAMPLE_VALID),
    .sample_data(SAMPLE_DATA),
    .lvl(lvl.source)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  logic tick;
  logic [HOLD_W-1:0] hold_limit;
  logic hold_done;
  logic [16:0] need_wide;
  volt_t headroom;
  volt_t ceiling;
  volt_t desired;
  volt_t step;
  logic [2:0] req;
  logic [2:0] lower;
  logic [5:0] thr_max;

  always_comb begin
    next_s = s;
    tick = (s.tick_cnt == TICK_W'(TICK_CYCLES - 1));
    hold_limit = HOLD_W'(HOLD_US) << s.tot; // R8
    hold_done = (s.hold_cnt >= hold_limit);
    headroom = 16'(HEAD_BASE_LSB + 16'(s.cfg[4][TGT_LSB +: CODE_W]) * STEP_LSB); // R4
    ceiling = 16'(CEIL_BASE_LSB + 16'(s.cfg[4][THR_LSB +: 4]) * STEP_LSB); // R5
    need_wide = {1'b0, lvl.est_level} + {1'b0, headroom}; // R3
    desired = (need_wide > {1'b0, ceiling}) ? ceiling : need_wide[15:0]; // R5
    step = SLEW_BASE_LSB << s.slew; // R10
    req = 3'd0;
    lower = 3'd0;
    thr_max = THR_CODE_MAX;

    // one-microsecond tick divider
    next_s.tick_cnt = tick ? '0 : s.tick_cnt + 1'b1;

    // highest level whose threshold the estimate exceeds
    for (int l = 1; l <= 4; l++) begin
      thr_max = (l == 4) ? THR_CODE_MAX_TOP : THR_CODE_MAX;
      if (pair_ok(s.cfg[l], thr_max) &&
          (lvl.est_level > thr_volt(s.cfg[l][THR_LSB +: CODE_W]))) begin
        req = 3'(l); // R14 R16
      end
      if (pair_ok(s.cfg[l], thr_max) && (3'(l) < s.level)) begin
        lower = 3'(l); // R17
      end
    end

    // hold counter runs on the tick until it expires
    if (tick && !hold_done) begin
      next_s.hold_cnt = s.hold_cnt + 1'b1;
    end

    if (s.class_h) begin
      // class-H tracking
      next_s.level = 3'd0;
      if (lvl.est_valid) begin
        next_s.last_need = desired;
        if (desired >= s.target) begin
          next_s.target = desired; // R9 R3
          next_s.hold_cnt = '0;
        end else if (desired > s.last_need) begin
          next_s.hold_cnt = '0; // R7
        end
      end else if (tick && hold_done && (s.target > s.last_need)) begin
        next_s.target = ((s.target - s.last_need) > step) ? 16'(s.target - step) :
                        s.last_need; // R6 R10
      end
      next_s.en = (next_s.target > VBAT_LEVEL); // R2
      next_s.bypass = !(next_s.target > VBAT_LEVEL);
    end else begin
      // class-G stepping
      unique case (s.mode) // R12
        MODE_OFF: begin
          next_s.level = 3'd0;
          next_s.en = 1'b0; // R22
          next_s.bypass = 1'b0;
          next_s.target = '0;
        end
        MODE_BATTERY: begin
          next_s.level = 3'd0;
          next_s.en = 1'b0;
          next_s.bypass = 1'b1; // R22
          next_s.target = '0;
        end
        MODE_FIXED: begin
          next_s.level = tgt_ok(s.cfg[4][TGT_LSB +: CODE_W]) ? 3'd4 : 3'd0;
          next_s.en = tgt_ok(s.cfg[4][TGT_LSB +: CODE_W]); // R21
          next_s.bypass = !tgt_ok(s.cfg[4][TGT_LSB +: CODE_W]);
          next_s.target = tgt_ok(s.cfg[4][TGT_LSB +: CODE_W]) ?
                          tgt_volt(s.cfg[4][TGT_LSB +: CODE_W]) : '0; // R21
        end
        MODE_ADAPTIVE: begin
          if (lvl.est_valid) begin
            next_s.req = req;
            if (req >= s.level) begin
              next_s.level = req; // R16 R9
              next_s.hold_cnt = '0;
            end
          end else if (tick && hold_done && (s.req < s.level)) begin
            next_s.level = lower; // R17 R15
            next_s.hold_cnt = '0;
          end
          next_s.en = (next_s.level != 3'd0); // R2
          next_s.bypass = (next_s.level == 3'd0); // R15
          next_s.target = (next_s.level == 3'd0) ? '0 :
                          tgt_volt(s.cfg[next_s.level][TGT_LSB +: CODE_W]); // R16
        end
      endcase
    end

    // register writes
    if (REG_WR) begin
      unique case (REG_ADDR)
        ADDR_CTRL: begin
          next_s.class_h = REG_WDATA[CLASS_H_BIT]; // R1 R13
          next_s.tot = REG_WDATA[TOT_LSB +: 2]; // R8
          next_s.slew = REG_WDATA[SLEW_LSB +: 2]; // R10
          next_s.mode = boost_mode_t'(REG_WDATA[MODE_LSB +: 2]); // R12
        end
        ADDR_LVL4: next_s.cfg[4] = REG_WDATA[CFG_W-1:0];
        ADDR_LVL3: next_s.cfg[3] = REG_WDATA[CFG_W-1:0];
        ADDR_LVL2: next_s.cfg[2] = REG_WDATA[CFG_W-1:0];
        ADDR_LVL1: next_s.cfg[1] = REG_WDATA[CFG_W-1:0];
        default: begin
        end
      endcase
    end

    // register reads, answered one cycle later; unmapped reads zero
    if (REG_RD) begin
      unique case (REG_ADDR)
        ADDR_CTRL: next_s.rdata = {7'h00, s.class_h, s.tot, s.slew, 2'b00, s.mode};
        ADDR_LVL4: next_s.rdata = {4'h0, s.cfg[4]};
        ADDR_LVL3: next_s.rdata = {4'h0, s.cfg[3]};
        ADDR_LVL2: next_s.rdata = {4'h0, s.cfg[2]};
        ADDR_LVL1: next_s.rdata = {4'h0, s.cfg[1]};
        ADDR_STATUS: next_s.rdata = {s.en, s.bypass, 11'h000, s.level};
        ADDR_TARGET: next_s.rdata = s.target;
        default: next_s.rdata = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s <= '0;
      s.class_h <= RST_CTRL[CLASS_H_BIT]; // R1
      s.tot <= RST_CTRL[TOT_LSB +: 2];
      s.slew <= RST_CTRL[SLEW_LSB +: 2];
      s.mode <= MODE_OFF;
      s.cfg[4] <= RST_LVL4[CFG_W-1:0]; // R4 R5
      s.cfg[3] <= RST_LVL3[CFG_W-1:0];
      s.cfg[2] <= RST_LVL2[CFG_W-1:0];
      s.cfg[1] <= RST_LVL1[CFG_W-1:0];
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign REG_RDATA = s.rdata;
  assign BOOST_ENABLE = s.en;
  assign BOOST_BYPASS = s.bypass;
  assign BOOST_TARGET = s.target;
  assign BOOST_LEVEL = s.level;

endmodule : boost_tracking_control

//--- rtl/boost_pkg.sv
// constants, register map and types for the boost tracking controller
// assumes one 20 MHz clock and 16-bit register words from the serial control port
//
// Summary of operation
// R1 - control bit 8 picks class-G stepping (0) or class-H tracking (1, reset)
// R2 - converter turns on by itself when estimated need exceeds battery voltage
// R3 - class-H target follows estimated output level plus programmed headroom
// R4 - headroom is 1.1 V plus code times 0.2 V, reset 1.7 V
// R5 - class-H target ceiling is 9.5 V plus low nibble times 0.2 V, reset 12.5 V
// R6 - a falling target holds for the hold period before it may decrease
// R7 - any signal increase during the hold restarts it, target does not drop
// R8 - hold timeout field bits 7:6 give 500 us, 1 ms (reset), 2 ms, 4 ms
// R9 - rising targets apply at once with no slew limit
// R10 - class-H falling slew is 0.75, 1.5 (reset), 3.0 or 6.0 mV per us
// R11 - class-H target derives from input samples well ahead of the DAC path
// R12 - mode field bits 1:0: disabled (reset), battery, fixed, adaptive
// R13 - software choosing a class-G mode also clears the class-H bit; the code loads the class-H bit from bit 8 of the same write
// R14 - class-G compares estimated output against the programmed thresholds
// R15 - adaptive mode bypasses the converter below the lowest threshold
// R16 - above a threshold the converter runs at that threshold's paired target
// R17 - below a threshold the level holds for the hold period, then steps down
// R18 - class-G decision derives from input samples ahead of the DAC path
// R19 - target code gives 2.9 V plus code times 0.2 V, zero disables, above 48 reserved
// R20 - threshold code gives 1.3 V plus code times 0.2 V, zero disables
// R21 - fixed mode holds the output at the highest target field's level
// R22 - disabled mode keeps the converter off, battery mode keeps it bypassed
package boost_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h40;
  localparam logic [7:0] ADDR_LVL4 = 8'h41;
  localparam logic [7:0] ADDR_LVL3 = 8'h42;
  localparam logic [7:0] ADDR_LVL2 = 8'h43;
  localparam logic [7:0] ADDR_LVL1 = 8'h44;
  localparam logic [7:0] ADDR_STATUS = 8'h46;
  localparam logic [7:0] ADDR_TARGET = 8'h47;

  localparam int CLASS_H_BIT = 8;
  localparam int TOT_LSB = 6;
  localparam int SLEW_LSB = 4;
  localparam int MODE_LSB = 0;
  localparam int TGT_LSB = 6;
  localparam int THR_LSB = 0;
  localparam int CODE_W = 6;
  localparam int CFG_W = 12;
  localparam int STAT_EN_BIT = 15;
  localparam int STAT_BYP_BIT = 14;

  localparam logic [15:0] RST_CTRL = 16'h0150;
  localparam logic [15:0] RST_LVL4 = 16'h00EF;
  localparam logic [15:0] RST_LVL3 = 16'h085B;
  localparam logic [15:0] RST_LVL2 = 16'h05CF;
  localparam logic [15:0] RST_LVL1 = 16'h02C7;

  // ----------------------------------------------------------------
  // voltage scale: one lsb is 0.25 mV
  // ----------------------------------------------------------------
  localparam int LSB_UV = 250;
  localparam int LSB_PER_MV = 1000 / LSB_UV;
  localparam int STEP_MV = 200;
  localparam int HEAD_BASE_MV = 1100;
  localparam int CEIL_BASE_MV = 9500;
  localparam int TARGET_BASE_MV = 2900;
  localparam int THRESH_BASE_MV = 1300;
  localparam logic [15:0] STEP_LSB = 16'(STEP_MV * LSB_PER_MV);
  localparam logic [15:0] HEAD_BASE_LSB = 16'(HEAD_BASE_MV * LSB_PER_MV);
  localparam logic [15:0] CEIL_BASE_LSB = 16'(CEIL_BASE_MV * LSB_PER_MV);
  localparam logic [15:0] TARGET_BASE_LSB = 16'(TARGET_BASE_MV * LSB_PER_MV);
  localparam logic [15:0] THRESH_BASE_LSB = 16'(THRESH_BASE_MV * LSB_PER_MV);
  localparam logic [5:0] TGT_CODE_MAX = 6'h30;
  localparam logic [5:0] THR_CODE_MAX_TOP = 6'h31;
  localparam logic [5:0] THR_CODE_MAX = 6'h30;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 20000;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = CLK_FREQ_KHZ * TICK_US / 1000;
  localparam int TICK_W = 5;
  localparam int HOLD_BASE_US = 500;
  localparam int HOLD_W = 13;
  localparam int SLEW_BASE_UV_PER_US = 750;
  localparam logic [15:0] SLEW_BASE_LSB = 16'(SLEW_BASE_UV_PER_US * TICK_US / LSB_UV);
  localparam int LEAD_H_US = 100;
  localparam int LEAD_G_US = 430;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_BATTERY,
    MODE_FIXED,
    MODE_ADAPTIVE
  } boost_mode_t;

  typedef logic [15:0] volt_t;

endpackage : boost_pkg

//--- rtl/level_if.sv
// estimated speaker output level passed from the estimator to the controller
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface level_if;
  logic est_valid;
  logic [15:0] est_level;

  modport source (output est_valid, output est_level);
  modport sink (input est_valid, input est_level);
endinterface : level_if

//--- rtl/level_estimator.sv
// peak estimator: turns each received audio sample into an output voltage
// assumes samples arrive as signed words with a one-cycle strobe on SYS_CLK
`timescale 1ns/1ps
module level_estimator #(
  parameter int SAMPLE_W = 24,
  parameter logic [15:0] FULL_SCALE_LSB = 16'hC350
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sample_valid,
  input wire logic [SAMPLE_W-1:0] sample_data,
  level_if.source lvl
);
  import boost_pkg::*;

  typedef struct packed {
    logic valid;
    logic [15:0] level;
  } est_state_t;

  est_state_t s;
  est_state_t next_s;
  logic [SAMPLE_W-1:0] mag;
  logic [SAMPLE_W+15:0] prod;

  // magnitude scaled by full-scale output, one cycle after the sample
  always_comb begin
    next_s = s;
    mag = sample_data[SAMPLE_W-1] ? SAMPLE_W'(~sample_data + 1'b1) : sample_data;
    prod = mag * FULL_SCALE_LSB;
    next_s.valid = sample_valid; // R11 R18
    if (sample_valid) begin
      next_s.level = prod[SAMPLE_W-1 +: 16]; // R11 R18
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign lvl.est_valid = s.valid;
  assign lvl.est_level = s.level;

endmodule : level_estimator

//--- sim/boost_chk_sva.sv
// checker: port assertions for the boost tracking controller
// assumes one clock and the register map of boost_pkg
`timescale 1ns/1ps
module boost_chk
  import boost_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic [15:0] REG_RDATA,
  input wire boost_pkg::volt_t VBAT_LEVEL,
  input wire logic BOOST_ENABLE,
  input wire logic BOOST_BYPASS,
  input wire boost_pkg::volt_t BOOST_TARGET,
  input wire logic [2:0] BOOST_LEVEL
);
  logic [15:0] ctrl;
  logic [1:0] quiet;
  logic h_on;
  logic g_on;
  // -------------------------------------------------
  // shadow control word, cycles since any write
  // -------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl <= RST_CTRL;
      quiet <= 2'h0;
    end else begin
      if (REG_WR && REG_ADDR == ADDR_CTRL) begin
        ctrl <= REG_WDATA & 16'h01F3;
      end
      quiet <= REG_WR ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
    end
  end
  // settled class selection
  assign h_on = ctrl[CLASS_H_BIT] && quiet == 2'h3;
  assign g_on = !ctrl[CLASS_H_BIT] && quiet == 2'h3;
  // -------------------------------------------------
  // assertions
  // -------------------------------------------------
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_B);
  a_ctrl_readback: assert property (
    REG_RD && !REG_WR && REG_ADDR == ADDR_CTRL |=> REG_RDATA == $past(ctrl))
    else $error("control word read back wrong");
  a_enable_need: assert property (
    h_on |-> BOOST_ENABLE == (BOOST_TARGET > $past(VBAT_LEVEL)))
    else $error("converter enable does not follow need");
  a_level_h: assert property (h_on |=> BOOST_LEVEL == 3'h0)
    else $error("level nonzero in tracking class");
  a_drop_slew: assert property (
    h_on && BOOST_TARGET < $past(BOOST_TARGET)
    |-> $past(BOOST_TARGET) - BOOST_TARGET <= (16'h0003 << ctrl[5:4]))
    else $error("target fell faster than slew");
  a_off_quiet: assert property (
    g_on && ctrl[1:0] == 2'h0 |-> !BOOST_ENABLE && !BOOST_BYPASS
    && BOOST_TARGET == 16'h0000 && BOOST_LEVEL == 3'h0)
    else $error("disabled mode not quiet");
  a_batt_bypass: assert property (
    g_on && ctrl[1:0] == 2'h1 |-> BOOST_BYPASS && !BOOST_ENABLE)
    else $error("battery mode not bypassed");
  a_fixed_top: assert property (
    g_on && ctrl[1:0] == 2'h2 |-> (BOOST_LEVEL == 3'h4 && BOOST_ENABLE)
    || (BOOST_BYPASS && BOOST_LEVEL == 3'h0))
    else $error("fixed mode not at top level");
  a_bypass_low: assert property (
    g_on && ctrl[1:0] == 2'h3 && BOOST_LEVEL == 3'h0
    |-> BOOST_BYPASS && !BOOST_ENABLE && BOOST_TARGET == 16'h0000)
    else $error("level zero without bypass");
  a_hold_step: assert property (
    g_on && ctrl[1:0] == 2'h3 && BOOST_LEVEL < $past(BOOST_LEVEL)
    |-> $past(BOOST_LEVEL, 2) == $past(BOOST_LEVEL, 8))
    else $error("level stepped down without hold");
endmodule : boost_chk
bind boost_tracking_control boost_chk chk_u (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA), .VBAT_LEVEL(VBAT_LEVEL), .BOOST_ENABLE(BOOST_ENABLE),
  .BOOST_BYPASS(BOOST_BYPASS), .BOOST_TARGET(BOOST_TARGET), .BOOST_LEVEL(BOOST_LEVEL));

//--- sim/host_model.sv
// host model: drives the register strobe port one access at a time
// assumes strobes are taken on the rising edge of clk
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic wr,
  output logic rd,
  output logic [7:0] addr,
  output logic [15:0] wdata,
  input wire logic [15:0] rdata
);
  // idle bus at time zero
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
  end
  // one write; released fields turn over so stale values never match
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    #5;
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #5;
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask : write_reg
  // one read; data is registered on the edge that takes the strobe
  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    #5;
    rd = 1'b1;
    addr = a;
    @(posedge clk);
    #5;
    rd = 1'b0;
    addr = ~a;
    d = rdata;
  endtask : read_reg
endmodule : host_model

//--- sim/boost_tracking_control_tb.sv
// testbench: random and corner stimulus for the boost tracking controller
// assumes host_model on the register port and the bound checker
`timescale 1ns/1ps
module boost_tracking_control_tb;
  import boost_pkg::*;
  localparam longint FS_LSB = 64'hC350;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_val, cfg, big;
  logic sample_valid = 1'b0;
  logic [23:0] sample_data = 24'h000000;
  logic [23:0] smp;
  volt_t vbat = 16'h3B60;
  logic boost_en, boost_byp;
  volt_t boost_tgt;
  logic [2:0] boost_lvl;
  logic [31:0] outs;
  logic [31:0] seed = 32'hE8D96357;
  logic [7:0] raddr [6] = '{ADDR_CTRL, ADDR_LVL4, ADDR_LVL3, ADDR_LVL2, ADDR_LVL1, 8'h45};
  logic [15:0] rval [6] = '{RST_CTRL, RST_LVL4, RST_LVL3, RST_LVL2, RST_LVL1, 16'h0000};
  int fails = 0;
  int checked = 0;
  assign outs = {11'h0, boost_en, boost_byp, boost_lvl, boost_tgt};
  always #25 clk = ~clk;
  host_model host_u (.clk(clk), .wr(reg_wr), .rd(reg_rd), .addr(reg_addr),
    .wdata(reg_wdata), .rdata(reg_rdata));
  boost_tracking_control #(.SAMPLE_W(24), .FULL_SCALE_LSB(16'(FS_LSB)), .HOLD_US(5)) dut_u (
    .SYS_CLK(clk), .RST_B(rst_b), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .SAMPLE_VALID(sample_valid),
    .SAMPLE_DATA(sample_data), .VBAT_LEVEL(vbat), .BOOST_ENABLE(boost_en),
    .BOOST_BYPASS(boost_byp), .BOOST_TARGET(boost_tgt), .BOOST_LEVEL(boost_lvl));
  // -------------------------------------------------
  // expectation helpers
  // -------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  // tracking target: estimate plus headroom, clamped to the ceiling
  function automatic volt_t need_h(input logic [23:0] s, input logic [15:0] c);
    longint m;
    longint n;
    m = s[23] ? -longint'($signed(s)) : longint'(s);
    n = ((m * FS_LSB) >> 23) + HEAD_BASE_LSB + c[11:6] * STEP_LSB;
    m = CEIL_BASE_LSB + c[3:0] * STEP_LSB;
    return volt_t'(n < m ? n : m);
  endfunction : need_h
  function automatic volt_t tgt_g(input logic [15:0] r);
    return TARGET_BASE_LSB + r[11:6] * STEP_LSB;
  endfunction : tgt_g
  function automatic logic [31:0] pk(input logic e, input logic b, input logic [2:0] l,
    input volt_t t);
    return {11'h0, e, b, l, t};
  endfunction : pk
  // -------------------------------------------------
  // bench tasks
  // -------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : cyc
  task automatic send(input logic [23:0] s);
    cyc(1);
    sample_valid = 1'b1;
    sample_data = s;
    cyc(1);
    sample_valid = 1'b0;
    sample_data = ~s;
  endtask : send
  task automatic rst_pulse();
    rst_b = 1'b0;
    cyc(4);
    rst_b = 1'b1;
  endtask : rst_pulse
  task automatic stop_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  // watchdog against a hang
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    stop_test();
  end
  // -------------------------------------------------
  // main sequence
  // -------------------------------------------------
  initial begin
    rst_pulse();
    foreach (raddr[i]) begin
      host_u.read_reg(raddr[i], rd_val);
      chk(rd_val, rval[i]);
    end
    for (int i = 0; i < 3; i++) begin
      seed = xorshift(seed);
      host_u.write_reg(ADDR_LVL3 + 8'(i), seed[15:0]);
      host_u.read_reg(ADDR_LVL3 + 8'(i), rd_val);
      chk(rd_val, seed[15:0] & 16'h0FFF);
    end
    $display("register test done");
    repeat (6) begin
      rst_pulse();
      seed = xorshift(seed);
      vbat = 16'h2EE0 + {2'b00, seed[29:16]};
      cfg = {4'h0, seed[11:0]};
      host_u.write_reg(ADDR_LVL4, cfg);
      seed = xorshift(seed);
      smp = seed[23:0];
      send(smp);
      cyc(2);
      chk(boost_tgt, need_h(smp, cfg));
      chk(boost_en, need_h(smp, cfg) > vbat);
    end
    $display("tracking random test done");
    rst_pulse();
    big = need_h(24'h400000, RST_LVL4);
    send(24'h400000);
    send(24'h000000);
    cyc(150);
    chk(boost_tgt, big);
    send(24'h200000);
    cyc(150);
    chk(boost_tgt, big);
    cyc(250);
    chk(big - boost_tgt > 16'd36 && big - boost_tgt < 16'd78, 1'b1);
    $display("tracking hold test done");
    rst_pulse();
    host_u.write_reg(ADDR_CTRL, 16'h0003);
    cyc(2);
    chk(outs, pk(1'b0, 1'b1, 3'h0, 16'h0000));
    send(24'h200000);
    cyc(2);
    chk(outs, pk(1'b1, 1'b0, 3'h1, tgt_g(RST_LVL1)));
    send(24'h400000);
    cyc(2);
    chk(outs, pk(1'b1, 1'b0, 3'h2, tgt_g(RST_LVL2)));
    send(24'h000000);
    cyc(60);
    chk(outs, pk(1'b1, 1'b0, 3'h2, tgt_g(RST_LVL2)));
    cyc(60);
    chk(outs, pk(1'b1, 1'b0, 3'h1, tgt_g(RST_LVL1)));
    cyc(130);
    chk(outs, pk(1'b0, 1'b1, 3'h0, 16'h0000));
    $display("adaptive test done");
    for (int m = 0; m < 3; m++) begin
      host_u.write_reg(ADDR_CTRL, 16'(m));
      cyc(3);
      chk(outs, m == 2 ? pk(1'b1, 1'b0, 3'h4, tgt_g(RST_LVL4)) : pk(1'b0, m == 1, 3'h0, 16'h0000));
    end
    host_u.write_reg(ADDR_CTRL, 16'h0103);
    cyc(3);
    chk(boost_lvl, 3'h0);
    $display("mode test done");
    stop_test();
  end
endmodule : boost_tracking_control_tb
